// ### hw/cc_host_ctrl.sv
// host side call control message encoder and decoder
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cc_consts.svh"

// Summary of operation
// - release request is code 0x04 plus handle
// - handle bytes keep bit 7 clear
// - sync messages carry zero handle byte
// - identity type byte is zero only
// - identity bit count byte is 0x28
// - identity bytes packed most significant first
// - sync answer is thirteen bytes with result
// - result zero accepts, one rejects
// - host alone starts calls toward handsets
// - host compares connect identity with request
// - host accepts all data after connect
// - host compares released handle with request
// - released handle is invalid until reassigned
// - messages travel on command channel, prot 0
// - call request twelve bytes, zero handle
module cc_host_ctrl
    import cc_pkg::*;
(
    // clock and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_RST_N,
    // ahb-lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    // message stream toward the module
    output logic             O_TX_VALID,
    output logic      [7:0]  O_TX_DATA,
    output logic             O_TX_LAST,
    output logic      [2:0]  O_TX_PROT,
    input  wire logic        I_TX_READY,
    // message stream from the module
    input  wire logic        I_RX_VALID,
    input  wire logic [7:0]  I_RX_DATA,
    input  wire logic        I_RX_LAST,
    input  wire logic [2:0]  I_RX_PROT,
    output logic             O_RX_READY
);

    cc_state_s st_q;  // registered state
    cc_state_s st_d;  // next state

    // one identity byte, first byte at the top
    function automatic logic [7:0] id_byte(input logic [63:0] id, input int k);
        id_byte = id[63 - 8 * k -: 8];
    endfunction

    // identity type and bit count fields are legal
    function automatic logic ident_ok(input cc_buf_t b);
        ident_ok = (b[2] == `CC_ID_TYPE_N) && (b[3] == `CC_ID_BITS);
    endfunction

    // gather identity bytes four to eleven
    function automatic logic [63:0] id_of(input cc_buf_t b);
        logic [63:0] r;
        r = 64'h0;
        for (int k = 0; k < 8; k++) begin
            r[63 - 8 * k -: 8] = b[4 + k];
        end
        id_of = r;
    endfunction

    // next state of the whole controller
    always_comb begin
        cc_buf_t    rb;     // receive buffer with current byte
        logic [3:0] n;      // byte count with current byte
        logic       conn;   // valid connect indication
        logic       disc;   // valid release indication
        logic       syncq;  // valid sync query
        logic       start;  // control register written
        logic [31:0] wd;    // write data of the data phase
        st_d  = st_q;
        rb    = st_q.rx_buf;
        n     = 4'h0;
        conn  = 1'b0;
        disc  = 1'b0;
        syncq = 1'b0;
        start = 1'b0;
        wd    = I_HWDATA;
        // bus answers are always ready and okay
        st_d.hready   = 1'b1;
        st_d.hresp    = 1'b0;
        st_d.wr_pend  = 1'b0;
        st_d.rx_ready = 1'b1;
        // all messages use the command channel
        st_d.prot     = `CC_PROT_CMD;

        // write data phase; clears happen before any set
        if (st_q.wr_pend) begin
            case (st_q.wr_addr)
                `CC_A_CTRL: begin
                    start = 1'b1;
                end
                `CC_A_TXH: begin
                    st_d.tx_handle = wd[6:0];
                end
                `CC_A_TXIDH: begin
                    st_d.tx_id[63:32] = wd;
                end
                `CC_A_TXIDL: begin
                    st_d.tx_id[31:0] = wd;
                end
                `CC_A_STAT: begin
                    st_d.sticky = st_q.sticky & ~wd[7:1];
                end
                default: begin
                    // unmapped writes are ignored
                end
            endcase
        end

        // start of a message toward the module
        if (start && (wd[2:0] != 3'h0)) begin
            if (st_q.tx_st != TX_IDLE) begin
                // busy: order refused
                st_d.sticky[`CC_ST_REFUSE] = 1'b1;
            end else if (wd[`CC_CTRL_CALL]) begin
                st_d.tx_kind = MSG_CALL;
                st_d.tx_len  = `CC_LEN_CALL;
                st_d.tx_buf  = '0;
                st_d.tx_buf[0] = `CC_CMD_CALL;
                st_d.tx_buf[1] = `CC_NO_HANDLE;
                st_d.tx_buf[2] = `CC_ID_TYPE_N;
                st_d.tx_buf[3] = `CC_ID_BITS;
                for (int k = 0; k < 8; k++) begin
                    st_d.tx_buf[4 + k] = id_byte(st_q.tx_id, k);
                end
                st_d.req_id   = st_q.tx_id;
                st_d.req_pend = 1'b1;
                st_d.tx_st    = TX_SEND;
            end else if (wd[`CC_CTRL_REL]) begin
                if (!st_q.valid_map[st_q.tx_handle]) begin
                    st_d.sticky[`CC_ST_REFUSE] = 1'b1;
                end else begin
                    st_d.tx_kind = MSG_REL;
                    st_d.tx_len  = `CC_LEN_REL;
                    st_d.tx_buf  = '0;
                    st_d.tx_buf[0] = `CC_CMD_REL;
                    st_d.tx_buf[1] = {1'b0, st_q.tx_handle};
                    st_d.rel_handle = st_q.tx_handle;
                    st_d.rel_pend   = 1'b1;
                    st_d.tx_st      = TX_SEND;
                end
            end else begin
                st_d.tx_kind = MSG_SYNC;
                st_d.tx_len  = `CC_LEN_SYNCA;
                st_d.tx_buf  = '0;
                st_d.tx_buf[0] = `CC_CMD_SYNCA;
                st_d.tx_buf[1] = `CC_NO_HANDLE;
                st_d.tx_buf[2] = `CC_ID_TYPE_N;
                st_d.tx_buf[3] = `CC_ID_BITS;
                for (int k = 0; k < 8; k++) begin
                    st_d.tx_buf[4 + k] = id_byte(st_q.tx_id, k);
                end
                st_d.tx_buf[12] = {7'h0, wd[`CC_CTRL_REJ]};
                st_d.tx_st      = TX_SEND;
            end
            if (st_d.tx_st == TX_SEND && st_q.tx_st == TX_IDLE) begin
                // first byte goes out next cycle
                st_d.tx_idx   = 4'h0;
                st_d.tx.valid = 1'b1;
                st_d.tx.last  = 1'b0;
                st_d.tx.data  = st_d.tx_buf[0];
            end
        end

        // byte handshake toward the module
        if (st_q.tx_st == TX_SEND && I_TX_READY) begin
            if (st_q.tx.last) begin
                // message done
                st_d.tx_st    = TX_IDLE;
                st_d.tx.valid = 1'b0;
                st_d.tx.last  = 1'b0;
            end else begin
                // next byte moves to the front
                st_d.tx_buf  = st_q.tx_buf >> 8;
                st_d.tx.data = st_q.tx_buf[1];
                st_d.tx_idx  = st_q.tx_idx + 4'h1;
                st_d.tx.last = (st_q.tx_idx + 4'h2) == st_q.tx_len;
            end
        end

        // only command channel bytes are collected
        if (I_RX_VALID && I_RX_PROT == `CC_PROT_CMD) begin
            if (st_q.rx_cnt < `CC_LEN_CONN) begin
                rb[st_q.rx_cnt] = I_RX_DATA;
            end
            // count saturates to mark an overlong message
            n = (st_q.rx_cnt == `CC_LEN_OVER) ? st_q.rx_cnt : st_q.rx_cnt + 4'h1;
            if (I_RX_LAST) begin
                st_d.rx_cnt = 4'h0;
                conn  = (rb[0] == `CC_CMD_CONN) && (n == `CC_LEN_CONN) &&
                        !rb[1][7] && ident_ok(rb);
                disc  = (rb[0] == `CC_CMD_DISC) && (n == `CC_LEN_DISC) &&
                        !rb[1][7] && ident_ok(rb);
                syncq = (rb[0] == `CC_CMD_SYNCQ) && (n == `CC_LEN_SYNCQ) &&
                        (rb[1] == `CC_NO_HANDLE) && ident_ok(rb);
            end else begin
                st_d.rx_buf = rb;
                st_d.rx_cnt = n;
            end
        end

        // anything else leaves call state alone
        if (I_RX_VALID && I_RX_PROT == `CC_PROT_CMD && I_RX_LAST &&
            !conn && !disc && !syncq) begin
            st_d.sticky[`CC_ST_DROP] = 1'b1;
        end

        if (conn) begin
            st_d.valid_map[rb[1][6:0]] = 1'b1;
            st_d.rx_handle = rb[1][6:0];
            st_d.rx_id     = id_of(rb);
            st_d.rx_callnr = rb[12];
            st_d.rx_code   = rb[0];
            st_d.sticky[`CC_ST_CONN] = 1'b1;
            if (st_q.req_pend && id_of(rb) != st_q.req_id) begin
                st_d.sticky[`CC_ST_OVLC] = 1'b1;
            end
            st_d.req_pend = 1'b0;
        end

        if (disc) begin
            st_d.valid_map[rb[1][6:0]] = 1'b0;
            st_d.rx_handle = rb[1][6:0];
            st_d.rx_id     = id_of(rb);
            st_d.rx_code   = rb[0];
            st_d.sticky[`CC_ST_DISC] = 1'b1;
            // other handle means handset release overlapped
            if (st_q.rel_pend && rb[1][6:0] != st_q.rel_handle) begin
                st_d.sticky[`CC_ST_OVLR] = 1'b1;
            end
            st_d.rel_pend = 1'b0;
        end

        // sync query waits for software to answer
        if (syncq) begin
            st_d.rx_id   = id_of(rb);
            st_d.rx_code = rb[0];
            st_d.sticky[`CC_ST_SYNCQ] = 1'b1;
        end

        // ahb address phase: latch writes, prepare reads
        if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
            if (I_HWRITE) begin
                st_d.wr_pend = 1'b1;
                st_d.wr_addr = I_HADDR[7:0];
            end else begin
                case (I_HADDR[7:0])
                    `CC_A_TXH: begin
                        st_d.hrdata = {25'h0, st_q.tx_handle};
                    end
                    `CC_A_TXIDH: begin
                        st_d.hrdata = st_q.tx_id[63:32];
                    end
                    `CC_A_TXIDL: begin
                        st_d.hrdata = st_q.tx_id[31:0];
                    end
                    `CC_A_STAT: begin
                        st_d.hrdata = {24'h0, st_q.sticky, st_q.tx_st == TX_SEND};
                    end
                    `CC_A_RXINFO: begin
                        st_d.hrdata = {8'h0, st_q.rx_code, st_q.rx_callnr,
                                       1'b0, st_q.rx_handle};
                    end
                    `CC_A_RXIDH: begin
                        st_d.hrdata = st_q.rx_id[63:32];
                    end
                    `CC_A_RXIDL: begin
                        st_d.hrdata = st_q.rx_id[31:0];
                    end
                    `CC_A_HVALID: begin
                        st_d.hrdata = {31'h0, st_q.valid_map[st_q.tx_handle]};
                    end
                    default: begin
                        // control and unmapped read as zero
                        st_d.hrdata = 32'h0;
                    end
                endcase
            end
        end
    end

    // state register with synchronous reset
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            st_q          <= '0;
            st_q.hready   <= 1'b1;
            st_q.rx_ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign O_HRDATA    = st_q.hrdata;
    assign O_HREADYOUT = st_q.hready;
    assign O_HRESP     = st_q.hresp;
    assign O_TX_VALID  = st_q.tx.valid;
    assign O_TX_DATA   = st_q.tx.data;
    assign O_TX_LAST   = st_q.tx.last;
    assign O_TX_PROT   = st_q.prot;
    assign O_RX_READY  = st_q.rx_ready;

    // checks on the transmitted and received streams
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);

    rel_code_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_REL && st_q.tx_idx == 4'h0
        |-> O_TX_DATA == `CC_CMD_REL) else $error("release code wrong");
    rel_len_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_REL && st_q.tx_idx == 4'h1
        |-> O_TX_LAST) else $error("release not two bytes");
    hnd_bit7_a: assert property (O_TX_VALID && st_q.tx_idx == 4'h1
        |-> !O_TX_DATA[7]) else $error("handle bit 7 set");
    sync_hnd_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_SYNC && st_q.tx_idx == 4'h1
        |-> O_TX_DATA == `CC_NO_HANDLE) else $error("sync handle not zero");
    id_type_a: assert property (O_TX_VALID && st_q.tx_kind != MSG_REL && st_q.tx_idx == 4'h2
        |-> O_TX_DATA == `CC_ID_TYPE_N) else $error("identity type wrong");
    id_bits_a: assert property (O_TX_VALID && st_q.tx_kind != MSG_REL && st_q.tx_idx == 4'h3
        |-> O_TX_DATA == `CC_ID_BITS) else $error("identity count wrong");
    id_order_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_CALL && st_q.tx_idx == 4'h4
        |-> O_TX_DATA == st_q.req_id[63:56]) else $error("identity order wrong");
    sync_len_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_SYNC
        |-> O_TX_LAST == (st_q.tx_idx == 4'hc)) else $error("answer length wrong");
    result_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_SYNC && O_TX_LAST
        |-> O_TX_DATA inside {8'h00, 8'h01}) else $error("bad result byte");
    call_len_a: assert property (O_TX_VALID && st_q.tx_kind == MSG_CALL
        |-> O_TX_LAST == (st_q.tx_idx == 4'hb)) else $error("call length wrong");
    tx_prot_a: assert property (O_TX_VALID
        |-> O_TX_PROT == `CC_PROT_CMD) else $error("wrong channel");
    rx_ready_a: assert property (O_RX_READY) else $error("receive stalled");
    drop_a: assert property (I_RX_VALID && I_RX_LAST && I_RX_PROT == `CC_PROT_CMD &&
        st_q.rx_cnt == 4'h0 && I_RX_DATA == `CC_CMD_CONN
        |=> $stable(st_q.valid_map) && st_q.sticky[`CC_ST_DROP]) else $error("short msg kept");
    // byte held while stalled
    tx_hold_a: assert property (O_TX_VALID && !I_TX_READY
        |=> O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST)) else $error("byte dropped");

endmodule
`default_nettype wire

// ### pkg/cc_consts.svh
// constants for the call control host controller
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH
// command codes
`define CC_CMD_CONN   8'h01
`define CC_CMD_DISC   8'h02
`define CC_CMD_CALL   8'h03
`define CC_CMD_REL    8'h04
`define CC_CMD_SYNCQ  8'h05
`define CC_CMD_SYNCA  8'h06
// message lengths in bytes
`define CC_LEN_CONN   4'hd
`define CC_LEN_DISC   4'hc
`define CC_LEN_CALL   4'hc
`define CC_LEN_REL    4'h2
`define CC_LEN_SYNCQ  4'hc
`define CC_LEN_SYNCA  4'hd
`define CC_LEN_OVER   4'he
// field values
`define CC_ID_TYPE_N  8'h00
`define CC_ID_BITS    8'h28
`define CC_NO_HANDLE  8'h00
`define CC_PROT_CMD   3'h0
// register byte offsets
`define CC_A_CTRL     8'h00
`define CC_A_TXH      8'h04
`define CC_A_TXIDH    8'h08
`define CC_A_TXIDL    8'h0c
`define CC_A_STAT     8'h10
`define CC_A_RXINFO   8'h14
`define CC_A_RXIDH    8'h18
`define CC_A_RXIDL    8'h1c
`define CC_A_HVALID   8'h20
// control bits
`define CC_CTRL_CALL  0
`define CC_CTRL_REL   1
`define CC_CTRL_SYNC  2
`define CC_CTRL_REJ   8
// sticky status bits
`define CC_ST_CONN    1
`define CC_ST_DISC    2
`define CC_ST_SYNCQ   3
`define CC_ST_OVLC    4
`define CC_ST_OVLR    5
`define CC_ST_DROP    6
`define CC_ST_REFUSE  7
`endif

// ### pkg/cc_pkg.sv
// types for the call control host controller
package cc_pkg;
    typedef enum logic [0:0] {TX_IDLE, TX_SEND} cc_tx_e;
    typedef enum logic [1:0] {MSG_CALL, MSG_REL, MSG_SYNC} cc_msg_e;
    typedef logic [12:0][7:0] cc_buf_t;
    // one byte of a link stream
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } cc_byte_s;
    // whole state of the controller
    typedef struct packed {
        cc_tx_e     tx_st;
        cc_msg_e    tx_kind;
        cc_buf_t    tx_buf;
        logic [3:0] tx_idx;
        logic [3:0] tx_len;
        cc_byte_s   tx;
        logic [2:0] prot;
        logic [63:0] tx_id;
        logic [6:0] tx_handle;
        logic [63:0] req_id;
        logic       req_pend;
        logic [6:0] rel_handle;
        logic       rel_pend;
        cc_buf_t    rx_buf;
        logic [3:0] rx_cnt;
        logic       rx_ready;
        logic [63:0] rx_id;
        logic [6:0] rx_handle;
        logic [7:0] rx_callnr;
        logic [7:0] rx_code;
        logic [7:1] sticky;
        logic [127:0] valid_map;
        logic       wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic       hready;
        logic       hresp;
    } cc_state_s;
endpackage

// ### verif/cc_dev_model.sv
// device side model of the call control link
`timescale 1ns/1ps
`default_nettype none
module cc_dev_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // bytes from the controller
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_last,
    input  wire logic [2:0] i_tx_prot,
    input  wire logic       i_stall,
    output logic            o_tx_ready,
    // bytes toward the controller
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_data,
    output logic            o_rx_last,
    output logic      [2:0] o_rx_prot,
    input  wire logic       i_rx_ready
);
    logic [11:0] cap [64]; // taken bytes as prot, last, data
    int          ncap;     // number of bytes taken so far
    // idle link at time zero
    initial begin
        o_rx_valid = 1'b0;
        o_rx_last  = 1'b0;
        o_rx_data  = 8'h00;
        o_rx_prot  = 3'h0;
    end
    // take bytes; a stall makes ready toggle every cycle
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ncap       <= 0;
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= i_stall ? !o_tx_ready : 1'b1;
            if (i_tx_valid && o_tx_ready) begin
                cap[ncap] <= {i_tx_prot, i_tx_last, i_tx_data};
                ncap      <= ncap + 1;
            end
        end
    end
    // send one message: code, handle, identity fields, optional tail byte
    task automatic send(input logic [7:0] c, input logic [7:0] h, input logic [63:0] id,
                        input logic [7:0] x, input int n);
        logic [7:0] b [13];
        b[0] = c;
        b[1] = h;
        b[2] = 8'h00;
        b[3] = 8'h28;
        for (int i = 0; i < 8; i++) b[4+i] = id[63-8*i -: 8];
        b[12] = x;
        o_rx_prot <= 3'h0;
        for (int i = 0; i < n; i++) begin
            o_rx_valid <= 1'b1;
            o_rx_data  <= b[i];
            o_rx_last  <= (i == n - 1);
            @(posedge i_clk);
            while (!i_rx_ready) @(posedge i_clk);
        end
        // released line shows the inverse of the last byte
        o_rx_valid <= 1'b0;
        o_rx_last  <= 1'b0;
        o_rx_data  <= ~b[n-1];
    endtask
endmodule
`default_nettype wire

// ### verif/cc_host_ctrl_test.sv
// testbench for the call control host controller
`timescale 1ns/1ps
`default_nettype none
module cc_host_ctrl_test
    import cc_pkg::*;
;
    logic        clk, rst_n, hsel, hwrite, hready, hresp, stall;
    logic [31:0] haddr, hwdata, hrdata, rd_d;
    logic [1:0]  htrans;
    logic [2:0]  hsize, tx_prot, rx_prot;
    logic        tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_ready;
    logic [7:0]  tx_data, rx_data;
    int          num_errors, checks, base;
    localparam logic [63:0] ID1 = 64'h12345678_9a000000; // forty bits, zero tail
    localparam logic [63:0] ID2 = 64'hfedcba98_76000000;
    localparam logic [7:0]  DC [5] = '{8'h07, 8'h01, 8'h05, 8'h01, 8'h01}; // bad codes, fields or lengths
    localparam logic [7:0]  DH [5] = '{8'h00, 8'h05, 8'h01, 8'h83, 8'h00};
    localparam int          DN [5] = '{12, 12, 12, 13, 1};
    // design under test
    cc_host_ctrl dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_TX_VALID(tx_valid),
        .O_TX_DATA(tx_data), .O_TX_LAST(tx_last), .O_TX_PROT(tx_prot), .I_TX_READY(tx_ready),
        .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data), .I_RX_LAST(rx_last), .I_RX_PROT(rx_prot),
        .O_RX_READY(rx_ready));
    // device model on the link
    cc_dev_model dev (.i_clk(clk), .i_rst_n(rst_n), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .i_tx_last(tx_last), .i_tx_prot(tx_prot), .i_stall(stall), .o_tx_ready(tx_ready),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_last(rx_last), .o_rx_prot(rx_prot),
        .i_rx_ready(rx_ready));
    // free running clock
    always #5 clk = ~clk;
    // verdict and end of run
    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one edge, then a bounded wait for hready
    task automatic edge_rdy();
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            k++;
            if (k > 50) begin
                num_errors++;
                $display("wrong value at %0t: bus wait ran out", $time);
                report_and_stop();
            end
            @(posedge clk);
        end
    endtask
    // single word write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr  <= {24'h0, a};
        edge_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        edge_rdy();
    endtask
    // single word read into rd_d
    task automatic rd(input logic [7:0] a);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr  <= {24'h0, a};
        edge_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        edge_rdy();
        rd_d = hrdata;
        // bus response must always be okay
        chk({31'h0, hresp}, 32'h0);
    endtask
    // compare sticky status, then clear it
    task automatic st_chk(input logic [31:0] e);
        rd(8'h10);
        chk(rd_d & 32'hfe, e);
        wr(8'h10, 32'h0000_00fe);
    endtask
    // bounded wait for n bytes taken since base
    task automatic wait_tx(input int n);
        for (int k = 0; k < 400 && dev.ncap != base + n; k++) @(posedge clk);
        if (dev.ncap != base + n) begin
            num_errors++;
            $display("wrong value at %0t: link wait ran out", $time);
            report_and_stop();
        end
        chk(dev.ncap - base, n);
    endtask
    // compare taken bytes with the expected layout, last flag and channel zero
    task automatic chk_tx(input logic [7:0] c, input logic [7:0] h, input logic [63:0] id,
                          input logic [7:0] x, input int n);
        logic [7:0] e;
        for (int i = 0; i < n; i++) begin
            e = (i == 0) ? c : (i == 1) ? h : (i == 2) ? 8'h00 : (i == 3) ? 8'h28 :
                (i < 12) ? id[63-8*(i-4) -: 8] : x;
            chk({20'h0, dev.cap[base+i]}, {20'h0, 3'h0, i == n - 1, e});
        end
    endtask
    // handset call, host release under stall, handle invalid afterwards
    task automatic t_release();
        dev.send(8'h01, 8'h05, ID1, 8'h81, 13);
        st_chk(32'h02);
        rd(8'h14);
        chk(rd_d, 32'h0001_8105);
        rd(8'h18);
        chk(rd_d, ID1[63:32]);
        wr(8'h04, 32'h05);
        rd(8'h20);
        chk(rd_d, 32'h1);
        stall <= 1'b1;
        base = dev.ncap;
        wr(8'h00, 32'h2);
        wait_tx(2);
        chk_tx(8'h04, 8'h05, ID1, 8'h00, 2);
        stall <= 1'b0;
        dev.send(8'h02, 8'h05, ID1, 8'h00, 12);
        st_chk(32'h04);
        rd(8'h20);
        chk(rd_d, 32'h0);
        base = dev.ncap;
        wr(8'h00, 32'h2);
        st_chk(32'h80);
        chk(dev.ncap, base);
    endtask
    // host call request, overlapping handset identity, handset release
    task automatic t_call();
        wr(8'h08, ID2[63:32]);
        wr(8'h0c, ID2[31:0]);
        base = dev.ncap;
        wr(8'h00, 32'h1);
        wait_tx(12);
        chk_tx(8'h03, 8'h00, ID2, 8'h00, 12);
        dev.send(8'h01, 8'h03, ID1, 8'h01, 13);
        st_chk(32'h12);
        // host release of handle 3 overlapped by a release of handle 5
        wr(8'h04, 32'h03);
        base = dev.ncap;
        wr(8'h00, 32'h2);
        wait_tx(2);
        dev.send(8'h02, 8'h05, ID1, 8'h00, 12);
        st_chk(32'h24);
        dev.send(8'h02, 8'h03, ID1, 8'h00, 12);
        st_chk(32'h04);
    endtask
    // sync query, then accept and reject answers
    task automatic t_sync();
        dev.send(8'h05, 8'h00, ID1, 8'h00, 12);
        st_chk(32'h08);
        rd(8'h1c);
        chk(rd_d, ID1[31:0]);
        for (int r = 0; r < 2; r++) begin
            base = dev.ncap;
            wr(8'h00, 32'h4 | (r << 8));
            // a second order while the answer is still going out is refused
            wr(8'h00, 32'h4);
            wait_tx(13);
            chk_tx(8'h06, 8'h00, ID2, r[7:0], 13);
            st_chk(32'h80);
        end
    endtask
    // malformed messages are dropped without state change
    task automatic t_drop();
        for (int k = 0; k < 5; k++) begin
            dev.send(DC[k], DH[k], ID1, 8'h81, DN[k]);
            st_chk(32'h40);
        end
        rd(8'h20);
        chk(rd_d, 32'h0);
    endtask
    // reset, scenarios, verdict
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        stall = 1'b0;
        num_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_release();
        t_call();
        t_sync();
        t_drop();
        report_and_stop();
    end
endmodule
`default_nettype wire
